// ===== tb/iso_tx_header_and_buffer_status_test.sv
// iso_tx_header_and_buffer_status_test.sv: register, key and buffer tests.
// assumes: itxhb_core with a 16-quadlet buffer, partner itxhb_app.
`timescale 1ns/10ps
`default_nettype none
`include "itxhb_map.svh"
module iso_tx_header_and_buffer_status_test;
    localparam int D = 16; // short buffer keeps the run small
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, txq_ready = 0, rx_valid = 0, rx_key = 0;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, r32;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic av_tx_valid, av_tx_ready, av_port_key_parity_pin, txq_valid, av_rx_valid, av_rx_key;
    itxhb_pkg::itxhb_byte_t rx_byte = '0, av_tx_byte, av_rx_byte;
    itxhb_pkg::itxhb_quad_t txq;
    itxhb_pkg::itxhb_hdr_t tx_hdr;
    int err_total = 0, checks = 0, k, n;
    initial forever #4 aclk = ~aclk;
    itxhb_core #(.DEPTH(D)) uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .av_tx_valid, .av_tx_byte,
        .av_port_key_parity_pin, .av_tx_ready, .txq_valid, .txq, .txq_ready, .tx_hdr, .rx_valid,
        .rx_byte, .rx_key, .av_rx_valid, .av_rx_byte, .av_rx_key, .irq);
    itxhb_app app (.aclk, .av_tx_ready, .av_tx_valid, .av_tx_byte, .av_port_key_parity_pin);
    task automatic give_verdict();
        $display("checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic to_chk();
        if (n >= 99) begin
            err_total++;
            give_verdict();
        end
    endtask : to_chk
    // one axi4-lite access; each channel released at its own handshake
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= w;
        s_axi_wvalid <= w;
        s_axi_bready <= w;
        s_axi_arvalid <= !w;
        s_axi_rready <= !w;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!(w ? s_axi_bvalid : s_axi_rvalid) && n < 99);
        to_chk();
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
        r32 = s_axi_rdata;
        rs = w ? s_axi_bresp : s_axi_rresp;
    endtask : acc
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        acc(1'b1, a, d);
        chk(rs, er);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        acc(1'b0, a, 32'h0);
        chk(r32, e);
        chk(rs, er);
    endtask : rd
    // expected status word for c quadlets stored
    function automatic logic [31:0] st(input int c);
        st = {25'h0, D - c <= 100, D - c <= 256, c >= D / 2, c == D, D - c == 1, D - c >= 5, c == 0};
    endfunction : st
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`ITXHB_OFS_CTL, 32'h0, 2'h0);
        rd(`ITXHB_OFS_STAT, st(0), 2'h0);
        for (k = 0; k < 4; k++) begin
            wr(`ITXHB_OFS_CTL, 32'h6A0F | (k << 4), 2'h0);
            rd(`ITXHB_OFS_CTL, 32'h6A00 | (k << 4), 2'h0);
            chk(tx_hdr, {2'h1, 6'h2A, k[1:0], 4'h0});
        end
        wr(`ITXHB_OFS_STAT, 32'hFFFFFFFF, 2'h0);
        rd(`ITXHB_OFS_STAT, st(0), 2'h0);
        wr(8'h3C, 32'h1, 2'h2);
        rd(8'h3C, 32'h0, 2'h2);
        wr(`ITXHB_OFS_INT_MASK, 32'h2, 2'h0);
        app.send(1'b1, D + 1);
        @(posedge aclk);
        chk(av_tx_ready, 1'b0);
        chk(txq.data, 32'h00010203);
        chk({txq.first, txq.key}, 2'h3);
        chk(tx_hdr.sync, 4'h2);
        chk(irq, 1'b1);
        wr(`ITXHB_OFS_INT_MASK, 32'h0, 2'h0);
        @(posedge aclk);
        chk(irq, 1'b0);
        wr(`ITXHB_OFS_INT_MASK, 32'h2, 2'h0);
        @(posedge aclk);
        chk(irq, 1'b1);
        wr(`ITXHB_OFS_INT_STAT, 32'h2, 2'h0);
        @(posedge aclk);
        chk(irq, 1'b0);
        // drain one quadlet at a time, status checked at every level
        for (k = D; k >= 0; k--) begin
            rd(`ITXHB_OFS_STAT, st(k), 2'h0);
            @(posedge aclk);
            txq_ready <= 1'b1;
            @(posedge aclk);
            txq_ready <= 1'b0;
        end
        app.send(1'b0, 1);
        n = 0;
        while (!txq_valid && n < 99) begin
            @(posedge aclk);
            n++;
        end
        to_chk();
        chk({txq.first, txq.key}, 2'h2);
        chk(tx_hdr.sync, 4'h0);
        rx_valid <= 1'b1;
        rx_byte <= '{8'hA5, 1'b1};
        rx_key <= 1'b1;
        @(posedge aclk);
        rx_byte <= '{8'h5A, 1'b0};
        rx_key <= 1'b0;
        @(posedge aclk);
        rx_valid <= 1'b0;
        @(posedge aclk);
        chk(av_rx_key, 1'b1);
        chk({av_rx_valid, av_rx_byte}, {1'b1, 8'h5A, 1'b0});
        give_verdict();
    end
    // hang guard
    initial begin
        repeat (20000) @(posedge aclk);
        err_total++;
        give_verdict();
    end
endmodule : iso_tx_header_and_buffer_status_test
`default_nettype wire

// ===== tb/itxhb_app.sv
// itxhb_app.sv: application codec feeding the transmit av port.
// assumes: send is called from the bench; ready sampled at rising edges.
`timescale 1ns/10ps
`default_nettype none
module itxhb_app (
    input  wire logic                  aclk,
    input  wire logic                  av_tx_ready,
    output var logic                   av_tx_valid,
    output var itxhb_pkg::itxhb_byte_t av_tx_byte,
    output var logic                   av_port_key_parity_pin
);
    initial begin
        av_tx_valid = 1'b0;
        av_tx_byte = '0;
        av_port_key_parity_pin = 1'b0;
    end
    // whole quadlets, one key per packet, sent one packet at a time
    task automatic send(input logic k, input int nq);
        int i;
        int n;
        @(posedge aclk);
        for (i = 0; i < nq * 4; i++) begin
            av_tx_valid <= 1'b1;
            av_tx_byte <= '{i[7:0], i == 0};
            av_port_key_parity_pin <= (i == 0) ? k : !k; // valid only at first byte
            n = 0;
            do begin
                @(posedge aclk);
                n++;
            end while (!av_tx_ready && n < 999);
        end
        av_tx_valid <= 1'b0;
        av_tx_byte <= ~av_tx_byte; // released lines do not keep the last byte
    endtask : send
endmodule : itxhb_app
`default_nettype wire

// ===== tb/itxhb_props.sv
// itxhb_props.sv: port-level checks of itxhb_core.
// assumes: bound to every itxhb_core instance, one clock domain.
`timescale 1ns/10ps
`default_nettype none
module itxhb_props (
    input wire logic                   aclk,
    input wire logic                   aresetn,
    input wire logic                   s_axi_bvalid,
    input wire logic                   s_axi_bready,
    input wire logic [1:0]             s_axi_bresp,
    input wire logic                   s_axi_arvalid,
    input wire logic                   s_axi_arready,
    input wire logic                   s_axi_rvalid,
    input wire logic                   s_axi_rready,
    input wire logic [31:0]            s_axi_rdata,
    input wire logic                   txq_valid,
    input wire logic                   txq_ready,
    input wire itxhb_pkg::itxhb_quad_t txq,
    input wire itxhb_pkg::itxhb_hdr_t  tx_hdr,
    input wire logic                   rx_valid,
    input wire itxhb_pkg::itxhb_byte_t rx_byte,
    input wire logic                   av_rx_valid,
    input wire logic                   av_rx_key
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // a stalled response must not move
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response changed while stalled");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data changed while stalled");
    AST_AR_ANS: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read not answered next cycle");
    AST_SY_RSVD: assert property (tx_hdr.sync[3:2] == 2'h0 && !tx_hdr.sync[0])
        else $error("sync bits other than key not zero");
    // quadlet and its key stay together until taken
    AST_Q_HOLD: assert property (txq_valid && !txq_ready |=> txq_valid && $stable(txq))
        else $error("quadlet changed while stalled");
    AST_HDR_KEY: assert property (txq_valid && txq.first |-> tx_hdr.sync[1] == txq.key)
        else $error("header key differs from packet key");
    AST_RX_DLY: assert property (1'b1 |=> av_rx_valid == $past(rx_valid))
        else $error("receive valid not one cycle late");
    // key only moves at a packet start
    AST_RX_KEY: assert property (!(rx_valid && rx_byte.first) |=> $stable(av_rx_key))
        else $error("receive key moved inside packet");
endmodule : itxhb_props
bind itxhb_core itxhb_props u_props (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .txq_valid,
    .txq_ready, .txq, .tx_hdr, .rx_valid, .rx_byte, .av_rx_valid, .av_rx_key);
`default_nettype wire

// ===== verilog/itxhb_core.sv
// itxhb_core.sv: isochronous transmit control, key tagging, buffer status,
// interrupt and receive key hold, behind an AXI4-Lite register slave.
// assumes: one clock aclk, synchronous active-low aresetn, av port inputs
// already synchronous to aclk, drain side obeys valid/ready.
//
// Contract
// - programmed tag goes into every header
// - programmed channel goes into every header
// - speed code 00/01/10 selects 100/200/400
// - read-only sync code, bit 1 key parity
// - key bit comes from the key pin
// - pin sampled at the packet's first byte
// - key stored with packet in buffer
// - receive output holds key for whole packet
// - bit 6 set at 100 quadlets left
// - bit 5 set at 256 quadlets left
// - bit 3 set when buffer full
// - bit 2 set when one quadlet left
// - bit 1 set when five or more free
// - bit 0 set when buffer empty
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "itxhb_map.svh"

module itxhb_core #(
    parameter int DEPTH = 1024  // transmit buffer depth in quadlets
) (
    input  wire logic                          aclk,
    input  wire logic                          aresetn,
    // axi4-lite slave
    input  wire logic [`ITXHB_ADDR_W-1:0]      s_axi_awaddr,
    input  wire logic [2:0]                    s_axi_awprot,
    input  wire logic                          s_axi_awvalid,
    output logic                               s_axi_awready,
    input  wire logic [31:0]                   s_axi_wdata,
    input  wire logic [3:0]                    s_axi_wstrb,
    input  wire logic                          s_axi_wvalid,
    output logic                               s_axi_wready,
    output logic [1:0]                         s_axi_bresp,
    output logic                               s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    input  wire logic [`ITXHB_ADDR_W-1:0]      s_axi_araddr,
    input  wire logic [2:0]                    s_axi_arprot,
    input  wire logic                          s_axi_arvalid,
    output logic                               s_axi_arready,
    output logic [31:0]                        s_axi_rdata,
    output logic [1:0]                         s_axi_rresp,
    output logic                               s_axi_rvalid,
    input  wire logic                          s_axi_rready,
    // transmit av port
    input  wire logic                          av_tx_valid,
    input  wire itxhb_pkg::itxhb_byte_t        av_tx_byte,
    input  wire logic                          av_port_key_parity_pin,
    output logic                               av_tx_ready,
    // quadlets toward the bus packet builder
    output logic                               txq_valid,
    output itxhb_pkg::itxhb_quad_t             txq,
    input  wire logic                          txq_ready,
    output itxhb_pkg::itxhb_hdr_t              tx_hdr,
    // received bytes and their key toward the receive av port
    input  wire logic                          rx_valid,
    input  wire itxhb_pkg::itxhb_byte_t        rx_byte,
    input  wire logic                          rx_key,
    output logic                               av_rx_valid,
    output itxhb_pkg::itxhb_byte_t             av_rx_byte,
    output logic                               av_rx_key,
    // interrupt, level
    output logic                               irq
);

    ////////////////////////////////////////////////////////////////////////////
    // local sizes and state

    localparam int CW = $clog2(DEPTH + 1);  // count width
    localparam int PW = $clog2(DEPTH);      // pointer width

    // every register of the block but the quadlet store in one word
    typedef struct packed {
        // axi write side
        logic                     aw_held;   // address taken, not yet used
        logic [`ITXHB_ADDR_W-1:0] aw_addr;
        logic                     w_held;    // data taken, not yet used
        logic [31:0]              w_data;
        logic [3:0]               w_strb;
        logic                     awready;
        logic                     wready;
        logic                     bvalid;
        logic [1:0]               bresp;
        // axi read side
        logic                     arready;
        logic                     rvalid;
        logic [31:0]              rdata;
        logic [1:0]               rresp;
        // software settings
        itxhb_pkg::itxhb_hdr_t    hdr;       // tag/channel/speed + live sync
        logic [`ITXHB_IRQ_W-1:0]  int_stat;  // sticky events
        logic [`ITXHB_IRQ_W-1:0]  int_mask;  // 1 lets the event through
        logic                     irq;
        // buffer bookkeeping
        logic [PW-1:0]            wr_ptr;
        logic [PW-1:0]            rd_ptr;
        logic [CW-1:0]            count;     // quadlets stored
        logic [`ITXHB_ST_W-1:0]   stat;      // buffer status flags
        logic                     in_ready;
        // byte packer
        logic [1:0]               idx;       // next byte lane
        logic [31:0]              pack;
        logic                     pack_first;
        logic                     pkt_key;   // key of the packet being packed
        // drain register
        logic                     q_valid;
        itxhb_pkg::itxhb_quad_t   q;
        // receive key hold
        logic                     rx_v;
        itxhb_pkg::itxhb_byte_t   rx_b;
        logic                     rx_k;
    } itxhb_state_t;

    itxhb_state_t s_r;    // registered state
    itxhb_state_t s_nxt;  // next state

    // quadlet store; no reset needed since count guards every read
    logic [33:0] mem_r [DEPTH];

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // byte-lane merge of a write into an old value
    function automatic logic [31:0] itxhb_merge(input logic [31:0] old_v,
                                                input logic [31:0] new_v,
                                                input logic [3:0]  strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction : itxhb_merge

    // buffer status flags from a fill count
    function automatic logic [`ITXHB_ST_W-1:0] itxhb_flags(input logic [CW-1:0] cnt);
        logic [`ITXHB_ST_W-1:0] f;
        int                     free_i;  // int so thresholds above DEPTH are not cut
        free_i = DEPTH - int'(cnt);
        f = '0;
        f[`ITXHB_ST_100_LEFT]  = (free_i <= `ITXHB_LEFT_100);
        f[`ITXHB_ST_256_LEFT]  = (free_i <= `ITXHB_LEFT_256);
        f[`ITXHB_ST_HALF]      = (int'(cnt) >= DEPTH / 2);
        f[`ITXHB_ST_FULL]      = (free_i == 0);
        f[`ITXHB_ST_ONE_LEFT]  = (free_i == 1);
        f[`ITXHB_ST_FIVE_FREE] = (free_i >= `ITXHB_FREE_5);
        f[`ITXHB_ST_EMPTY]     = (cnt == '0);
        return f;
    endfunction : itxhb_flags

    ////////////////////////////////////////////////////////////////////////////
    // next-state logic

    logic                     wr_go;     // register write happens now
    logic                     q_push;    // completed quadlet enters the store
    logic                     q_pop;     // store head moves to drain register
    logic [31:0]              packed_q;  // quadlet being completed
    logic [`ITXHB_IRQ_W-1:0]  ev;        // event pulses this cycle
    logic [`ITXHB_IRQ_W-1:0]  w1c;       // bits cleared by software
    logic [31:0]              rd_word;   // read mux
    logic                     rd_ok;     // read address mapped

    // one combinational pass fills every next value
    always_comb begin
        s_nxt    = s_r;
        packed_q = s_r.pack;
        q_push   = 1'b0;
        w1c      = '0;

        // write address and data taken in either order
        if (s_axi_awvalid && s_r.awready) begin
            s_nxt.aw_held = 1'b1;
            s_nxt.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_r.wready) begin
            s_nxt.w_held = 1'b1;
            s_nxt.w_data = s_axi_wdata;
            s_nxt.w_strb = s_axi_wstrb;
        end
        if (s_r.bvalid && s_axi_bready) begin
            s_nxt.bvalid = 1'b0;
        end

        // register write once both halves are held and no answer waits
        wr_go = s_r.aw_held && s_r.w_held && !s_r.bvalid;
        if (wr_go) begin
            s_nxt.aw_held = 1'b0;
            s_nxt.w_held  = 1'b0;
            s_nxt.bvalid  = 1'b1;
            s_nxt.bresp   = `ITXHB_RESP_OKAY;
            case (s_r.aw_addr)
                `ITXHB_OFS_CTL: begin
                    // only tag, channel, speed change; sync stays hardware-owned
                    logic [31:0] m;
                    m = itxhb_merge({16'h0, s_r.hdr.tag, s_r.hdr.channel, 2'h0,
                                     s_r.hdr.speed, 4'h0},
                                    s_r.w_data, s_r.w_strb);
                    s_nxt.hdr.tag     = m[`ITXHB_CTL_TAG_LSB +: 2];
                    s_nxt.hdr.channel = m[`ITXHB_CTL_CH_LSB +: 6];
                    s_nxt.hdr.speed   = itxhb_pkg::itxhb_speed_t'(m[`ITXHB_CTL_SPD_LSB +: 2]);
                end
                `ITXHB_OFS_STAT: begin
                    // status is read-only; write answered but dropped
                    s_nxt.bresp = `ITXHB_RESP_OKAY;
                end
                `ITXHB_OFS_INT_STAT: begin
                    // write one to clear, lowest byte only
                    if (s_r.w_strb[0]) begin
                        w1c = s_r.w_data[`ITXHB_IRQ_W-1:0];
                    end
                end
                `ITXHB_OFS_INT_MASK: begin
                    logic [31:0] mm;
                    mm = itxhb_merge({27'h0, s_r.int_mask}, s_r.w_data, s_r.w_strb);
                    s_nxt.int_mask = mm[`ITXHB_IRQ_W-1:0];
                end
                default: begin
                    s_nxt.bresp = `ITXHB_RESP_SLVERR;  // unmapped
                end
            endcase
        end
        s_nxt.awready = !s_nxt.aw_held;
        s_nxt.wready  = !s_nxt.w_held;

        // read mux
        rd_ok   = 1'b1;
        rd_word = 32'h0;
        case (s_axi_araddr)
            `ITXHB_OFS_CTL: begin
                rd_word[`ITXHB_CTL_TAG_LSB +: 2]  = s_r.hdr.tag;
                rd_word[`ITXHB_CTL_CH_LSB +: 6]   = s_r.hdr.channel;
                rd_word[`ITXHB_CTL_SPD_LSB +: 2]  = s_r.hdr.speed;
                rd_word[`ITXHB_CTL_SYNC_LSB +: 4] = s_r.hdr.sync;
            end
            `ITXHB_OFS_STAT: begin
                rd_word[`ITXHB_ST_W-1:0] = s_r.stat;
            end
            `ITXHB_OFS_INT_STAT: begin
                rd_word[`ITXHB_IRQ_W-1:0] = s_r.int_stat;
            end
            `ITXHB_OFS_INT_MASK: begin
                rd_word[`ITXHB_IRQ_W-1:0] = s_r.int_mask;
            end
            default: begin
                rd_ok = 1'b0;
            end
        endcase

        // read answer one cycle after the address is taken
        if (s_r.rvalid && s_axi_rready) begin
            s_nxt.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_r.arready) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rdata  = rd_word;
            s_nxt.rresp  = rd_ok ? `ITXHB_RESP_OKAY : `ITXHB_RESP_SLVERR;
        end
        s_nxt.arready = !s_nxt.rvalid;

        // byte packer: first byte lands in [31:24]
        if (av_tx_valid && s_r.in_ready) begin
            logic [1:0] lane;
            lane = av_tx_byte.first ? 2'h0 : s_r.idx;
            if (av_tx_byte.first) begin
                // key fixed by the pin at the first byte only
                s_nxt.pkt_key    = av_port_key_parity_pin;
                s_nxt.pack_first = 1'b1;
            end
            packed_q = s_r.pack;
            packed_q[(3 - lane) * 8 +: 8] = av_tx_byte.data;
            s_nxt.pack = packed_q;
            s_nxt.idx  = lane + 2'h1;
            if (lane == 2'h3) begin
                q_push = 1'b1;
                s_nxt.pack_first = 1'b0;
            end
        end

        // drain register refills from a non-empty store whenever empty or being taken
        q_pop = (s_r.count != '0) && (!s_r.q_valid || txq_ready);
        if (s_r.q_valid && txq_ready) begin
            s_nxt.q_valid = 1'b0;
        end
        if (q_pop) begin
            s_nxt.q_valid = 1'b1;
            s_nxt.q       = itxhb_pkg::itxhb_quad_t'(mem_r[s_r.rd_ptr]);
            s_nxt.rd_ptr  = (s_r.rd_ptr == PW'(DEPTH - 1)) ? '0 : s_r.rd_ptr + PW'(1);
            if (mem_r[s_r.rd_ptr][1]) begin
                // sy key bit follows the packet now heading out
                s_nxt.hdr.sync = 4'h0;
                s_nxt.hdr.sync[`ITXHB_SYNC_KEY_BIT] = mem_r[s_r.rd_ptr][0];
            end
        end
        if (q_push) begin
            s_nxt.wr_ptr = (s_r.wr_ptr == PW'(DEPTH - 1)) ? '0 : s_r.wr_ptr + PW'(1);
        end
        // count moves by push minus pop
        case ({q_push, q_pop})
            2'b10:   s_nxt.count = s_r.count + CW'(1);
            2'b01:   s_nxt.count = s_r.count - CW'(1);
            default: s_nxt.count = s_r.count;
        endcase
        // ready low while full, so a completed quadlet always has room
        s_nxt.in_ready = (s_nxt.count < CW'(DEPTH));
        s_nxt.stat     = itxhb_flags(s_nxt.count);

        // events on rising status flags; set beats a same-cycle clear
        ev = '0;
        ev[`ITXHB_IRQ_EMPTY]    = s_nxt.stat[`ITXHB_ST_EMPTY]    && !s_r.stat[`ITXHB_ST_EMPTY];
        ev[`ITXHB_IRQ_FULL]     = s_nxt.stat[`ITXHB_ST_FULL]     && !s_r.stat[`ITXHB_ST_FULL];
        ev[`ITXHB_IRQ_HALF]     = s_nxt.stat[`ITXHB_ST_HALF]     && !s_r.stat[`ITXHB_ST_HALF];
        ev[`ITXHB_IRQ_256_LEFT] = s_nxt.stat[`ITXHB_ST_256_LEFT] && !s_r.stat[`ITXHB_ST_256_LEFT];
        ev[`ITXHB_IRQ_100_LEFT] = s_nxt.stat[`ITXHB_ST_100_LEFT] && !s_r.stat[`ITXHB_ST_100_LEFT];
        s_nxt.int_stat = (s_r.int_stat & ~w1c) | ev;
        s_nxt.irq      = |(s_nxt.int_stat & s_nxt.int_mask);

        // receive side: key latched at the first byte, held to packet end
        s_nxt.rx_v = rx_valid;
        if (rx_valid) begin
            s_nxt.rx_b = rx_byte;
            if (rx_byte.first) begin
                s_nxt.rx_k = rx_key;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register

    // synchronous reset to documented values
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r            <= '0;
            s_r.hdr        <= itxhb_pkg::itxhb_hdr_t'(`ITXHB_CTL_RESET);
            s_r.stat       <= `ITXHB_STAT_RESET;
            s_r.awready    <= 1'b1;
            s_r.wready     <= 1'b1;
            s_r.arready    <= 1'b1;
            s_r.in_ready   <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // store write; key and first travel beside the data
    always_ff @(posedge aclk) begin
        if (q_push) begin
            mem_r[s_r.wr_ptr] <= {packed_q, s_r.pack_first, s_nxt.pkt_key};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs, all straight from state

    assign s_axi_awready = s_r.awready;
    assign s_axi_wready  = s_r.wready;
    assign s_axi_bvalid  = s_r.bvalid;
    assign s_axi_bresp   = s_r.bresp;
    assign s_axi_arready = s_r.arready;
    assign s_axi_rvalid  = s_r.rvalid;
    assign s_axi_rdata   = s_r.rdata;
    assign s_axi_rresp   = s_r.rresp;
    assign av_tx_ready   = s_r.in_ready;
    assign txq_valid     = s_r.q_valid;
    assign txq           = s_r.q;
    assign tx_hdr        = s_r.hdr;
    assign av_rx_valid   = s_r.rx_v;
    assign av_rx_byte    = s_r.rx_b;
    assign av_rx_key     = s_r.rx_k;
    assign irq           = s_r.irq;

endmodule : itxhb_core
`default_nettype wire

// ===== verilog/itxhb_map.svh
// itxhb_map.svh: offsets, field positions, reset values and thresholds of the
// isochronous transmit header and buffer status block.
// assumes: included by bare name from the block and the test.
`ifndef ITXHB_MAP_SVH
`define ITXHB_MAP_SVH

// register byte offsets on the 8-bit AXI4-Lite address
`define ITXHB_ADDR_W          8
`define ITXHB_OFS_CTL         8'h34
`define ITXHB_OFS_STAT        8'h38
`define ITXHB_OFS_INT_STAT    8'h80
`define ITXHB_OFS_INT_MASK    8'h84

// control register fields
`define ITXHB_CTL_TAG_LSB     14
`define ITXHB_CTL_CH_LSB      8
`define ITXHB_CTL_SPD_LSB     4
`define ITXHB_CTL_SYNC_LSB    0
`define ITXHB_SYNC_KEY_BIT    1
`define ITXHB_CTL_RESET       32'h0000_0000
`define ITXHB_TAG_AV_STREAM   2'h1

// buffer status bits
`define ITXHB_ST_100_LEFT     6
`define ITXHB_ST_256_LEFT     5
`define ITXHB_ST_HALF         4
`define ITXHB_ST_FULL         3
`define ITXHB_ST_ONE_LEFT     2
`define ITXHB_ST_FIVE_FREE    1
`define ITXHB_ST_EMPTY        0
`define ITXHB_ST_W            7
`define ITXHB_STAT_RESET      7'h03

// free-space thresholds in quadlets
`define ITXHB_LEFT_100        100
`define ITXHB_LEFT_256        256
`define ITXHB_FREE_5          5

// interrupt status / mask bits
`define ITXHB_IRQ_EMPTY       0
`define ITXHB_IRQ_FULL        1
`define ITXHB_IRQ_HALF        2
`define ITXHB_IRQ_256_LEFT    3
`define ITXHB_IRQ_100_LEFT    4
`define ITXHB_IRQ_W           5

// axi responses
`define ITXHB_RESP_OKAY       2'h0
`define ITXHB_RESP_SLVERR     2'h2

`endif

// ===== verilog/itxhb_pkg.sv
// itxhb_pkg.sv: types shared by the block and its bench.
// assumes: nothing beyond the map header.
package itxhb_pkg;

    // cable speed codes, 11 reserved
    typedef enum logic [1:0] {
        ITXHB_S100  = 2'h0,
        ITXHB_S200  = 2'h1,
        ITXHB_S400  = 2'h2,
        ITXHB_SRSVD = 2'h3
    } itxhb_speed_t;

    // one byte on an av port
    typedef struct packed {
        logic [7:0] data;   // byte value
        logic       first;  // first byte of a packet
    } itxhb_byte_t;

    // one quadlet leaving the transmit buffer
    typedef struct packed {
        logic [31:0] data;  // first byte in [31:24]
        logic        first; // first quadlet of a packet
        logic        key;   // key parity captured at the first byte
    } itxhb_quad_t;

    // isochronous header fields offered to the packet builder
    typedef struct packed {
        logic [1:0]   tag;     // tag field
        logic [5:0]   channel; // channel number
        itxhb_speed_t speed;   // cable speed
        logic [3:0]   sync;    // sy field, bit 1 key parity
    } itxhb_hdr_t;

endpackage : itxhb_pkg
